/* rtl/guard_tick_gen.sv */
// tick generator: one pulse per second and per minute
`timescale 1ns/100ps
module guard_tick_gen #(
	parameter longint unsigned SEC_CYCLES  = lockup_guard_pkg::SEC_CYCLES,
	parameter int unsigned     SEC_PER_MIN =
		int'(lockup_guard_pkg::SEC_PER_MIN)
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic restart_i,
	output logic      sec_tick_o,
	output logic      min_tick_o
);

	// refuse tick lengths the 32-bit and 8-bit counters cannot hold
	if (SEC_CYCLES < 2 || SEC_CYCLES > 64'h0000_0000_FFFF_FFFF ||
		SEC_PER_MIN < 1 || SEC_PER_MIN > 255) begin : g_bad_tick
		$error("guard_tick_gen: bad tick parameters");
	end

	logic [31:0] cyc_r;
	logic [7:0]  sec_r;

	// prescaler restarts on service so the first step is a full unit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || restart_i) begin
			cyc_r      <= 32'h0000_0000;
			sec_r      <= 8'h00;
			sec_tick_o <= 1'b0;
			min_tick_o <= 1'b0;
		end else begin
			sec_tick_o <= 1'b0;
			min_tick_o <= 1'b0;
			if (cyc_r == 32'(SEC_CYCLES - 1)) begin
				cyc_r      <= 32'h0000_0000;
				sec_tick_o <= 1'b1;
				if (sec_r == 8'(SEC_PER_MIN - 1)) begin
					sec_r      <= 8'h00;
					min_tick_o <= 1'b1;
				end else begin
					sec_r <= sec_r + 8'h01;
				end
			end else begin
				cyc_r <= cyc_r + 32'h0000_0001;
			end
		end
	end

endmodule : guard_tick_gen

/* rtl/lockup_guard_pkg.sv */
// constants and types for the lockup guard timer
//
// Summary of operation
// - control register at offset 0x06: enable, unit
// - control bit 0: guard off or on
// - control bit 1: seconds when 0, minutes when 1
// - offset 0x07 holds minute count, minute unit
// - minute countdown reaches 255 minutes at most
// - offset 0x08 holds second count, second unit
// - second countdown reaches 255 seconds at most
// - enabled: decrement per unit, reset at zero
// - rewriting active count register reloads counter
// - clearing enable halts countdown, no reset
package lockup_guard_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// shared ram offsets
	localparam logic [7:0] OFS_CONTROL = 8'h06;
	localparam logic [7:0] OFS_MINUTE  = 8'h07;
	localparam logic [7:0] OFS_SECOND  = 8'h08;

	// control fields
	localparam int unsigned CTL_ON_BIT   = 0;
	localparam int unsigned CTL_UNIT_BIT = 1;
	localparam logic [7:0]  CTL_USED     = 8'h03;

	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_COUNT   = 8'h00;

	// timing at 200 MHz
	localparam longint unsigned CLK_HZ       = 200000000;
	localparam longint unsigned SEC_PER_MIN  = 60;
	localparam longint unsigned TICK_S       = 1;
	localparam longint unsigned SEC_CYCLES   = TICK_S * CLK_HZ;
	localparam int unsigned     PULSE_NS     = 1000;
	localparam int unsigned     CLK_NS       = 5;
	localparam int unsigned     PULSE_CYCLES =
		(PULSE_NS + CLK_NS - 1) / CLK_NS;

	// one host access to shared ram
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ram_req_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_COUNT = 2'b01,
		ST_FIRE  = 2'b11
	} guard_state_t;

endpackage : lockup_guard_pkg

/* rtl/lockup_guard_timer.sv */
// lockup guard timer: shared ram registers, countdown, board reset
`timescale 1ns/100ps
module lockup_guard_timer #(
	parameter longint unsigned SEC_CYCLES   = lockup_guard_pkg::SEC_CYCLES,
	parameter int unsigned     PULSE_CYCLES = lockup_guard_pkg::PULSE_CYCLES
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire lockup_guard_pkg::ram_req_t ram_req_i,
	output logic [7:0]                     ram_rdata_o,
	output logic                           ram_rvalid_o,
	output logic                           board_reset_o,
	output logic                           guard_running_o
);

	// refuse pulse lengths the 16-bit pulse counter cannot hold
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
		$error("lockup_guard_timer: bad pulse length");
	end

	////////////////////////////////////////////////////////////////////
	// registers and state

	logic [7:0]                      control_r;
	logic [7:0]                      minute_r;
	logic [7:0]                      second_r;
	logic [7:0]                      count_r;
	logic [15:0]                     pulse_r;
	lockup_guard_pkg::guard_state_t  state_r;

	logic guard_on_bit;
	logic guard_unit_select;
	logic wr_ctl;
	logic wr_min;
	logic wr_sec;
	logic service;
	logic sec_tick;
	logic min_tick;
	logic unit_tick;
	logic stop;
	logic fire;

	assign guard_on_bit      = control_r[lockup_guard_pkg::CTL_ON_BIT];
	assign guard_unit_select = control_r[lockup_guard_pkg::CTL_UNIT_BIT];

	// host writes, decoded per offset
	assign wr_ctl = ram_req_i.wr &&
		(ram_req_i.addr == lockup_guard_pkg::OFS_CONTROL);
	assign wr_min = ram_req_i.wr &&
		(ram_req_i.addr == lockup_guard_pkg::OFS_MINUTE);
	assign wr_sec = ram_req_i.wr &&
		(ram_req_i.addr == lockup_guard_pkg::OFS_SECOND);

	// only a write to the count of the active unit services the guard
	assign service = guard_unit_select ? wr_min : wr_sec;

	assign unit_tick = guard_unit_select ? min_tick : sec_tick;
	// a disable write wins over a timeout in the same cycle, so a
	// late stop never leaks a one-cycle board reset
	assign stop = !guard_on_bit || (wr_ctl &&
		!ram_req_i.wdata[lockup_guard_pkg::CTL_ON_BIT]);
	assign fire = (state_r == lockup_guard_pkg::ST_COUNT) &&
		(count_r == 8'h00) && !stop;

	////////////////////////////////////////////////////////////////////
	// tick source

	// prescaler restarts whenever counting (re)starts
	guard_tick_gen #(
		.SEC_CYCLES  (SEC_CYCLES),
		.SEC_PER_MIN (int'(lockup_guard_pkg::SEC_PER_MIN))
	) guard_tick_gen_inst (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.restart_i  (service || state_r != lockup_guard_pkg::ST_COUNT),
		.sec_tick_o (sec_tick),
		.min_tick_o (min_tick)
	);

	////////////////////////////////////////////////////////////////////
	// host visible registers

	// timeout returns every register to its reset value
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || fire) begin
			control_r <= lockup_guard_pkg::RST_CONTROL;
			minute_r  <= lockup_guard_pkg::RST_COUNT;
			second_r  <= lockup_guard_pkg::RST_COUNT;
		end else begin
			if (wr_ctl)
				control_r <= ram_req_i.wdata &
					lockup_guard_pkg::CTL_USED;
			if (wr_min)
				minute_r <= ram_req_i.wdata;
			if (wr_sec)
				second_r <= ram_req_i.wdata;
		end
	end

	// read port, one cycle latency; unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ram_rdata_o  <= 8'h00;
			ram_rvalid_o <= 1'b0;
		end else begin
			ram_rvalid_o <= ram_req_i.rd;
			case (ram_req_i.addr)
				lockup_guard_pkg::OFS_CONTROL: ram_rdata_o <= control_r;
				lockup_guard_pkg::OFS_MINUTE:  ram_rdata_o <= minute_r;
				lockup_guard_pkg::OFS_SECOND:  ram_rdata_o <= second_r;
				default:                       ram_rdata_o <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// countdown state machine

	// the count loads from the active register at start and on service;
	// a unit change mid-count switches the tick source at once; the count keeps its value
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= lockup_guard_pkg::ST_IDLE;
			count_r <= 8'h00;
			pulse_r <= 16'h0000;
		end else begin
			case (state_r)
				lockup_guard_pkg::ST_IDLE: begin
					if (guard_on_bit) begin
						state_r <= lockup_guard_pkg::ST_COUNT;
						count_r <= guard_unit_select ? minute_r
							: second_r;
					end
				end
				lockup_guard_pkg::ST_COUNT: begin
					if (stop) begin
						state_r <= lockup_guard_pkg::ST_IDLE;
					end else if (fire) begin
						state_r <= lockup_guard_pkg::ST_FIRE;
						pulse_r <= 16'(PULSE_CYCLES - 1);
					end else if (service) begin
						count_r <= ram_req_i.wdata;
					end else if (unit_tick) begin
						count_r <= count_r - 8'h01;
					end
				end
				lockup_guard_pkg::ST_FIRE: begin
					if (pulse_r == 16'h0000)
						state_r <= lockup_guard_pkg::ST_IDLE;
					else
						pulse_r <= pulse_r - 16'h0001;
				end
				default: state_r <= lockup_guard_pkg::ST_IDLE;
			endcase
		end
	end

	// outputs straight from flops
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			board_reset_o   <= 1'b0;
			guard_running_o <= 1'b0;
		end else begin
			board_reset_o   <= fire ||
				(state_r == lockup_guard_pkg::ST_FIRE &&
				pulse_r != 16'h0000);
			guard_running_o <= state_r == lockup_guard_pkg::ST_COUNT;
		end
	end

endmodule : lockup_guard_timer

/* tb/lockup_guard_timer_monitor.sv */
// port checker for the lockup guard timer
`timescale 1ns/100ps
module lockup_guard_timer_monitor #(
	parameter longint unsigned SEC_CYCLES   = 10,
	parameter int unsigned     PULSE_CYCLES = 4
) (
	input wire logic                       clk_i,
	input wire logic                       rst_n_i,
	input wire lockup_guard_pkg::ram_req_t ram_req_i,
	input wire logic [7:0]                 ram_rdata_o,
	input wire logic                       ram_rvalid_o,
	input wire logic                       board_reset_o,
	input wire logic                       guard_running_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////
	// control write that clears the enable bit
	wire logic off_w = ram_req_i.wr && ram_req_i.addr == 8'h06
		&& !ram_req_i.wdata[0];
	int unsigned hi_cnt;
	// length of the current reset pulse
	always_ff @(posedge clk_i) begin
		hi_cnt <= board_reset_o ? hi_cnt + 1 : 0;
	end
	////////////////////////////////////////////////////////////////////
	a_rvalid_after_rd: assert property (ram_req_i.rd |=> ram_rvalid_o)
		else $error("read not answered");
	a_rvalid_needs_rd: assert property (ram_rvalid_o |-> $past(ram_req_i.rd))
		else $error("answer without read");
	a_ctrl_top_zero: assert property (ram_req_i.rd && ram_req_i.addr == 8'h06
		|=> ram_rdata_o[7:2] == 6'h00) else $error("unused bits set");
	a_pulse_fixed_len: assert property ($fell(board_reset_o)
		|-> hi_cnt == PULSE_CYCLES) else $error("pulse length wrong");
	a_fire_after_count: assert property ($rose(board_reset_o)
		|-> $past(guard_running_o)) else $error("reset while idle");
	a_fire_not_running: assert property (board_reset_o
		&& $past(board_reset_o) |-> !guard_running_o) else $error("runs");
	a_off_stops_run: assert property (off_w |-> ##[1:3] !guard_running_o)
		else $error("disable ignored");
	a_off_no_fire: assert property (off_w |=> (!$rose(board_reset_o))[*3])
		else $error("reset after disable");
	cover property ($rose(board_reset_o));
	cover property (off_w && guard_running_o);
	cover property (ram_req_i.rd && ram_req_i.addr > 8'h08);
endmodule : lockup_guard_timer_monitor

bind lockup_guard_timer lockup_guard_timer_monitor #(
	.SEC_CYCLES(SEC_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)
) lockup_guard_timer_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.ram_req_i(ram_req_i), .ram_rdata_o(ram_rdata_o),
	.ram_rvalid_o(ram_rvalid_o), .board_reset_o(board_reset_o),
	.guard_running_o(guard_running_o));

/* tb/lockup_guard_timer_tb.sv */
// self-checking bench for the lockup guard timer
`timescale 1ns/100ps
module lockup_guard_timer_tb;
	logic                       clk_i = 1'b0;
	logic                       rst_n_i = 1'b0;
	lockup_guard_pkg::ram_req_t ram_req_i = '0;
	logic [7:0]                 ram_rdata_o;
	logic                       ram_rvalid_o;
	logic                       board_reset_o;
	logic                       guard_running_o;
	int                         n_fail = 0;
	int                         total_checks = 0;
	int                         cyc = 0;
	int                         n;

	always #2.5 clk_i = ~clk_i;

	// short counts keep the run brief
	lockup_guard_timer #(.SEC_CYCLES(10), .PULSE_CYCLES(4))
	lockup_guard_timer_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ram_req_i(ram_req_i), .ram_rdata_o(ram_rdata_o),
		.ram_rvalid_o(ram_rvalid_o), .board_reset_o(board_reset_o),
		.guard_running_o(guard_running_o));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk

	// one access; an idle edge always separates two of them
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge clk_i);
		#1 ram_req_i = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_i);
		#1 ram_req_i = '0;
	endtask : acc

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk({ram_rvalid_o, ram_rdata_o}, {1'b1, e});
	endtask : rd

	// bounded wait for the board reset
	task automatic wait_fire(input int lim);
		n = 0;
		while (board_reset_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask : wait_fire

	task automatic arm(input logic [7:0] a, input logic m, input logic [7:0] c);
		acc(1'b1, 8'h06, {6'h00, m, 1'b0});
		acc(1'b1, a, c);
		acc(1'b1, 8'h06, {6'h00, m, 1'b1});
	endtask : arm
	////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		acc(1'b1, 8'h06, 8'hFE);
		rd(8'h06, 8'h02);
		acc(1'b1, 8'h07, 8'hFF);
		rd(8'h07, 8'hFF);
		acc(1'b1, 8'h08, 8'hFF);
		rd(8'h08, 8'hFF);
	endtask : t_regs

	task automatic t_fire(input logic m, input int lo, hi);
		arm(m ? 8'h07 : 8'h08, m, m ? 8'h01 : 8'h03);
		wait_fire(700);
		chk({8'h00, n >= lo && n <= hi}, 9'h001);
		n = 0;
		while (board_reset_o === 1'b1 && n < 20) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk(9'(n), 9'd4);
		rd(8'h06, 8'h00);
		rd(m ? 8'h07 : 8'h08, 8'h00);
	endtask : t_fire

	task automatic t_service();
		arm(8'h08, 1'b0, 8'h03);
		for (int i = 0; i < 5; i++) begin
			wait_fire(20);
			chk(9'(n), 9'd20);
			acc(1'b1, 8'h08, 8'h03);
		end
		chk({8'h00, guard_running_o}, 9'h001);
		acc(1'b1, 8'h06, 8'h00);
		wait_fire(60);
		chk({guard_running_o, 8'(n)}, 9'd60);
		// zero count: the disable lands on the very edge that would fire
		arm(8'h08, 1'b0, 8'h00);
		acc(1'b1, 8'h06, 8'h00);
		wait_fire(20);
		chk({board_reset_o, 8'(n)}, 9'd20);
	endtask : t_service
	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// hang guard, well above the expected length
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		t_regs();
		t_fire(1'b0, 30, 36);
		t_fire(1'b1, 598, 608);
		t_service();
		print_verdict();
	end
endmodule : lockup_guard_timer_tb
